// file: mfpc_core.sv
// Instruction sequencing core: phases, fetch pipeline, banked PC, return stack, ALU
//
// Summary of operation
// - Four Gray-coded phases on CYCLE_PHASE make one instruction cycle.
// - PC advances and next instruction is fetched at start of T1.
// - Fetch overlaps execute, giving one plain instruction per cycle.
// - Extended instructions take two cycles; branching ones one cycle more.
// - Jump or call: one cycle gets the target, the next branches.
// - Otherwise the PC rises by exactly one per instruction.
// - PC is bank field, five high bits and an eight-bit low byte.
// - Only the PC low byte is software readable and writable.
// - Writing the low byte jumps within the page, adding one dummy cycle.
// - A met skip discards the prefetched instruction for a dummy cycle.
// - Jump, call, interrupt and reset load the target into the PC.
// - Eight-level stack holds only PCs and is hidden from software.
// - Call or interrupt acknowledge pushes the PC.
// - Subroutine or interrupt return pops the PC.
// - Reset points the stack pointer at the top of the stack.
// - Full stack holds an interrupt pending until a return pops.
// - Call on full stack still runs and drops the oldest entry.
// - The ALU works on 8-bit operands through the accumulator.
// - ALU results go to the named destination and update flags.
// - Add, subtract, carry forms, adjust, logic, rotates, inc, dec, skip tests.
// - After reset fetching starts at address zero.
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ns
module mfpc_core #(
  parameter int BANK_W = mfpc_pkg::BANK_BITS,
  parameter int SDEPTH = mfpc_pkg::STACK_LEVELS
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [BANK_W+mfpc_pkg::PC_HI_W+mfpc_pkg::PC_LO_W-1:0] PM_ADDR,
  input wire logic [15:0] PM_DATA,
  output logic [7:0] DM_ADDR,
  output logic [7:0] DM_WDATA,
  output logic DM_WE,
  input wire logic [7:0] DM_RDATA,
  input wire logic INT_REQ,
  input wire logic [12:0] INT_VECTOR,
  output logic INT_ACK,
  output logic [1:0] CYCLE_PHASE
);
  import mfpc_pkg::*;

  localparam int PC_W = BANK_W + PC_HI_W + PC_LO_W;
  localparam int SP_W = $clog2(SDEPTH);

  if (BANK_W < 1 || BANK_W > 2 || !(SDEPTH == 2 || SDEPTH == 4 || SDEPTH == 8)) begin : g_chk
    $error("mfpc_core: unsupported BANK_W or SDEPTH");
  end

  mfpc_phase_t phase;
  logic [PC_W-1:0] pc;
  logic [15:0] ir;
  logic ext_stage;
  logic [7:0] acc;
  logic c_f, ac_f, z_f, ov_f;
  logic [PC_W-1:0] stk [SDEPTH];
  logic [SP_W-1:0] sp;
  logic [SP_W:0] depth;
  logic take_skip, pcl_pend, int_pend;
  logic [7:0] pcl_val;
  logic [BANK_W-1:0] bank;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [3:0] cls;
  mfpc_alu_t func;
  logic [1:0] sk;
  logic is_jmp, is_call, is_ret, is_ext, is_skip, t4, full, ext_first;
  logic exec_now, wr_mem, inst_pcl_wr;
  logic do_jmp, do_call, do_ret, do_pcl, do_skip, do_int, do_seq;
  logic [SP_W-1:0] sp_m1;
  logic [PC_W-1:0] stk_top;

  assign cls = ir[15:12];
  assign func = mfpc_alu_t'(ir[11:8]);
  assign sk = ir[9:8];
  assign is_jmp = ir[15:13] == TOP_JUMP;
  assign is_call = ir[15:13] == TOP_CALL;
  assign is_ret = cls == CL_RET;
  assign is_ext = cls == CL_LALU;
  assign is_skip = cls == CL_SKIP;
  assign t4 = phase == PH_T4;
  assign full = depth == (SP_W+1)'(SDEPTH);
  assign ext_first = is_ext && !ext_stage;
  // Extended op computes in its second cycle
  assign exec_now = phase == PH_T3 && (!is_ext || ext_stage);
  assign wr_mem = cls == CL_ALU_MEM || is_ext || (is_skip && (sk == SK_SIZ || sk == SK_SDZ));
  assign inst_pcl_wr = exec_now && wr_mem && ir[7:0] == DM_PCL_ADDR;
  assign sp_m1 = sp - 1'b1;
  assign stk_top = stk[sp_m1];

  // Priority of control transfers at the end of T4
  assign do_jmp = t4 && is_jmp;
  assign do_call = t4 && is_call;
  assign do_ret = t4 && is_ret;
  assign do_pcl = t4 && !ext_first && pcl_pend && !is_jmp && !is_call && !is_ret;
  assign do_skip = t4 && take_skip && !pcl_pend;
  // A full stack withholds acknowledge; the request stays pending
  assign do_int = t4 && !ext_first && int_pend && !full && !is_jmp && !is_call && !is_ret
                  && !pcl_pend && !take_skip;
  assign do_seq = t4 && !ext_first && !is_jmp && !is_call && !is_ret && !pcl_pend
                  && !take_skip && !do_int;

  // ----------------------------------------------------------------
  // Phase generator
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      phase <= PH_T1;
    end else begin
      unique case (phase)
        PH_T1: phase <= PH_T2;
        PH_T2: phase <= PH_T3;
        PH_T3: phase <= PH_T4;
        PH_T4: phase <= PH_T1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Program counter and instruction register
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      pc <= PC_W'(RESET_ADDR);
      ir <= OP_NOP;
      ext_stage <= 1'b0;
    end else if (t4) begin
      ext_stage <= ext_first;
      if (ext_first) begin
        ir <= ir;
      end else if (is_jmp || is_call) begin
        pc <= {bank, ir[12:0]};
        ir <= OP_NOP;
      end else if (is_ret) begin
        pc <= stk_top;
        ir <= OP_NOP;
      end else if (pcl_pend) begin
        // Page stays, only the low byte moves
        pc <= {pc[PC_W-1:PC_LO_W], pcl_val};
        ir <= OP_NOP;
      end else if (take_skip) begin
        pc <= pc + PC_W'(1);
        ir <= OP_NOP;
      end else if (do_int) begin
        pc <= {BANK_W'(0), INT_VECTOR};
        ir <= OP_NOP;
      end else begin
        pc <= pc + PC_W'(1);
        ir <= PM_DATA;
      end
    end
  end

  // ----------------------------------------------------------------
  // Return stack
  // ----------------------------------------------------------------
  // Circular store: a push on a full stack overwrites the oldest entry
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      sp <= '0;
      depth <= '0;
    end else if (do_call || do_int) begin
      stk[sp] <= pc;
      sp <= sp + 1'b1;
      depth <= full ? depth : depth + 1'b1;
    end else if (do_ret && depth != '0) begin
      sp <= sp_m1;
      depth <= depth - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // ALU
  // ----------------------------------------------------------------
  logic [7:0] b, bx, res, sk_res, mem_res;
  logic [8:0] sum;
  logic [4:0] hs;
  logic cin, n_c, n_ac, n_ov, z_upd, skip_hit;

  assign b = cls == CL_ALU_IMM ? ir[7:0] : (ir[7:0] == DM_PCL_ADDR ? pc[7:0] : DM_RDATA);

  always_comb begin
    bx = b;
    cin = 1'b0;
    res = acc;
    n_c = c_f;
    n_ac = ac_f;
    n_ov = ov_f;
    sum = '0;
    hs = '0;
    z_upd = 1'b1;
    unique case (func)
      ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
        bx = (func == ALU_SUB || func == ALU_SBC) ? ~b : b;
        cin = func == ALU_SUB ? 1'b1 : (func == ALU_ADD ? 1'b0 : c_f);
        sum = {1'b0, acc} + {1'b0, bx} + {8'h00, cin};
        hs = {1'b0, acc[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
        res = sum[7:0];
        n_c = sum[8];
        n_ac = hs[4];
        n_ov = (acc[7] == bx[7]) && (sum[7] != acc[7]);
      end
      ALU_DAA: begin
        sum = {1'b0, acc} + {1'b0, (acc[3:0] > BCD_MAX || ac_f) ? DAA_LO : 8'h00};
        if (sum[7:4] > BCD_MAX || c_f || sum[8]) begin
          sum = sum + DAA_HI;
        end
        res = sum[7:0];
        n_c = c_f | sum[8];
      end
      ALU_AND: res = acc & b;
      ALU_OR: res = acc | b;
      ALU_XOR: res = acc ^ b;
      ALU_CPL: res = ~b;
      ALU_RR: begin
        res = {b[0], b[7:1]};
        z_upd = 1'b0;
      end
      ALU_RRC: begin
        res = {c_f, b[7:1]};
        n_c = b[0];
        z_upd = 1'b0;
      end
      ALU_RL: begin
        res = {b[6:0], b[7]};
        z_upd = 1'b0;
      end
      ALU_RLC: begin
        res = {b[6:0], c_f};
        n_c = b[7];
        z_upd = 1'b0;
      end
      ALU_INC: res = b + 8'h01;
      ALU_DEC: res = b - 8'h01;
      ALU_MOVA: begin
        res = acc;
        z_upd = 1'b0;
      end
    endcase
  end

  // Skip tests leave the flags alone
  always_comb begin
    unique case (sk)
      SK_SIZ: sk_res = b + 8'h01;
      SK_SDZ: sk_res = b - 8'h01;
      SK_SZ, SK_SNZ: sk_res = b;
    endcase
    skip_hit = sk == SK_SNZ ? sk_res != 8'h00 : sk_res == 8'h00;
  end

  assign mem_res = is_skip ? sk_res : res;

  // ----------------------------------------------------------------
  // Execute and write back at the end of T3
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      acc <= 8'h00;
      {c_f, ac_f, z_f, ov_f} <= 4'h0;
      take_skip <= 1'b0;
      DM_WE <= 1'b0;
      DM_WDATA <= 8'h00;
      DM_ADDR <= 8'h00;
    end else begin
      if (phase == PH_T1) begin
        DM_ADDR <= ir[7:0];
      end
      if (t4) begin
        take_skip <= 1'b0;
        DM_WE <= 1'b0;
      end else if (exec_now) begin
        take_skip <= is_skip && skip_hit;
        if (cls == CL_ALU_IMM || cls == CL_ALU_ACC) begin
          acc <= res;
        end
        if (wr_mem && !inst_pcl_wr) begin
          DM_WE <= 1'b1;
          DM_WDATA <= mem_res;
        end
        if (cls == CL_ALU_IMM || cls == CL_ALU_ACC || cls == CL_ALU_MEM || is_ext) begin
          c_f <= n_c;
          ac_f <= n_ac;
          ov_f <= n_ov;
          z_f <= z_upd ? res == 8'h00 : z_f;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave: PROGRAM_COUNTER_LOW_BYTE, STATUS, CTRL; zero wait states
  // ----------------------------------------------------------------
  logic setup_ph, acc_ph, hit;
  logic [31:0] status;

  assign setup_ph = PSEL && !PENABLE;
  assign acc_ph = PSEL && PENABLE;
  assign hit = PADDR == ADDR_PCL || PADDR == ADDR_STATUS || PADDR == ADDR_CTRL;
  assign PREADY = 1'b1;
  assign PSLVERR = acc_ph && !hit;
  assign PM_ADDR = pc;
  assign CYCLE_PHASE = phase;

  always_comb begin
    status = '0;
    status[ST_ACC_LSB +: 8] = acc;
    status[ST_FLAG_LSB +: 4] = {ov_f, z_f, ac_f, c_f};
    status[ST_DEPTH_LSB +: SP_W+1] = depth;
    status[ST_PEND_BIT] = int_pend;
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      PRDATA <= 32'h0000_0000;
      bank <= '0;
    end else begin
      if (setup_ph) begin
        unique case (1'b1)
          PADDR == ADDR_PCL: PRDATA <= {24'h00_0000, pc[7:0]};
          PADDR == ADDR_STATUS: PRDATA <= status;
          PADDR == ADDR_CTRL: PRDATA <= 32'(bank);
          default: PRDATA <= 32'h0000_0000;
        endcase
      end
      if (acc_ph && PWRITE && PADDR == ADDR_CTRL) begin
        bank <= PWDATA[CTRL_BANK_LSB +: BANK_W];
      end
    end
  end

  // Low-byte write from the bus or from an instruction; set wins over consume
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      pcl_pend <= 1'b0;
      pcl_val <= 8'h00;
    end else if (acc_ph && PWRITE && PADDR == ADDR_PCL) begin
      pcl_pend <= 1'b1;
      pcl_val <= PWDATA[7:0];
    end else if (inst_pcl_wr) begin
      pcl_pend <= 1'b1;
      pcl_val <= mem_res;
    end else if (do_pcl) begin
      pcl_pend <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt acknowledge
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      int_pend <= 1'b0;
      INT_ACK <= 1'b0;
    end else begin
      INT_ACK <= do_int;
      if (INT_REQ) begin
        int_pend <= 1'b1;
      end else if (do_int) begin
        int_pend <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_phase_ring;
    phase == PH_T2 ##1 phase == PH_T3 ##1 phase == PH_T4 ##1 phase == PH_T1;
  endsequence
  sequence s_dummy;
    ir == OP_NOP;
  endsequence

  AST_PHASE_RING: assert property (phase == PH_T1 |=> s_phase_ring)
    else $error("phase ring broken");
  AST_FETCH_T1: assert property (do_seq |=> phase == PH_T1 && pc == $past(pc) + PC_W'(1)
    && ir == $past(PM_DATA))
    else $error("sequential fetch wrong");
  AST_ONE_PER_CYCLE: assert property (do_seq |=> (!t4) [*3] ##1 t4)
    else $error("instruction rate wrong");
  AST_EXT_TWO: assert property (t4 && ext_first |=> ext_stage && pc == $past(pc) ##4 !ext_stage)
    else $error("extended timing wrong");
  AST_JUMP: assert property (do_jmp |=> pc == {$past(bank), $past(ir[12:0])} ##0 s_dummy)
    else $error("jump target or dummy wrong");
  AST_PCL_PAGE: assert property (do_pcl |=> pc[PC_W-1:PC_LO_W] == $past(pc[PC_W-1:PC_LO_W])
    && pc[7:0] == $past(pcl_val) ##0 s_dummy)
    else $error("low byte jump wrong");
  AST_SKIP: assert property (do_skip |=> pc == $past(pc) + PC_W'(1) ##0 s_dummy)
    else $error("skip wrong");
  AST_PUSH: assert property (do_call || do_int |=> depth == ($past(full) ? $past(depth)
    : $past(depth) + 1'b1) && stk[$past(sp)] == $past(pc))
    else $error("push wrong");
  AST_POP: assert property (do_ret |=> pc == $past(stk_top) ##0 s_dummy)
    else $error("pop wrong");
  AST_RESET: assert property ($fell(SYS_RST) |-> pc == PC_W'(RESET_ADDR) && sp == '0
    && depth == '0)
    else $error("reset state wrong");
  AST_FULL_WAIT: assert property (do_ret && int_pend && !pcl_pend |=> ##3 (do_int || pcl_pend
    || take_skip))
    else $error("pending interrupt not served after return");
  AST_ADD: assert property (exec_now && cls == CL_ALU_IMM && func == ALU_ADD |=> acc == $past(acc)
    + $past(ir[7:0]) && z_f == (acc == 8'h00))
    else $error("add result or zero flag wrong");
endmodule : mfpc_core

// file: mfpc_pkg.sv
// Shared constants and types of the instruction sequencing core
package mfpc_pkg;
  // ----------------------------------------------------------------
  // Program counter and stack geometry
  // ----------------------------------------------------------------
  localparam int PC_LO_W = 8;
  localparam int PC_HI_W = 5;
  localparam int STACK_LEVELS = 8;
  localparam int BANK_BITS = 2;
  localparam logic [12:0] RESET_ADDR = 13'h0000;
  // ----------------------------------------------------------------
  // APB register map and fields
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_PCL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_CTRL = 12'h008;
  localparam int ST_ACC_LSB = 0;
  localparam int ST_FLAG_LSB = 8;
  localparam int ST_DEPTH_LSB = 12;
  localparam int ST_PEND_BIT = 16;
  localparam int CTRL_BANK_LSB = 0;
  // ----------------------------------------------------------------
  // Instruction encoding
  // ----------------------------------------------------------------
  localparam logic [15:0] OP_NOP = 16'h0000;
  localparam logic [3:0] CL_ALU_IMM = 4'h1;
  localparam logic [3:0] CL_ALU_ACC = 4'h2;
  localparam logic [3:0] CL_ALU_MEM = 4'h3;
  localparam logic [3:0] CL_SKIP = 4'h4;
  localparam logic [3:0] CL_RET = 4'h5;
  localparam logic [3:0] CL_LALU = 4'h6;
  localparam logic [2:0] TOP_CALL = 3'h6;
  localparam logic [2:0] TOP_JUMP = 3'h7;
  localparam logic [1:0] SK_SZ = 2'h0;
  localparam logic [1:0] SK_SNZ = 2'h1;
  localparam logic [1:0] SK_SIZ = 2'h2;
  localparam logic [1:0] SK_SDZ = 2'h3;
  localparam logic [7:0] DM_PCL_ADDR = 8'h06;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [7:0] DAA_LO = 8'h06;
  localparam logic [8:0] DAA_HI = 9'h060;

  typedef enum logic [1:0] {
    PH_T1 = 2'b00, PH_T2 = 2'b01, PH_T3 = 2'b11, PH_T4 = 2'b10
  } mfpc_phase_t;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DAA, ALU_AND, ALU_OR, ALU_XOR,
    ALU_CPL, ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC, ALU_DEC, ALU_MOVA
  } mfpc_alu_t;
endpackage : mfpc_pkg

// file: mfpc_mem_model.sv
// Far-side model of the core: program memory and data memory
`timescale 1ns/1ns
module mfpc_mem_model (
  input wire logic clk,
  input wire logic [14:0] pm_addr,
  output logic [15:0] pm_data,
  input wire logic [7:0] dm_addr,
  input wire logic [7:0] dm_wdata,
  input wire logic dm_we,
  output logic [7:0] dm_rdata
);
  import mfpc_pkg::*;
  // ----------------------------------------------------------------
  // Storage, filled by the bench before reset is released
  // ----------------------------------------------------------------
  logic [15:0] pm [0:32767];
  logic [7:0] dm [0:255];
  initial begin
    for (int i = 0; i < 32768; i++) pm[i] = OP_NOP;
    for (int i = 0; i < 256; i++) dm[i] = 8'h00;
  end
  // Combinational reads, as the core samples them late in the cycle
  assign pm_data = pm[pm_addr];
  assign dm_rdata = dm[dm_addr];
  always @(posedge clk) begin
    if (dm_we) dm[dm_addr] <= dm_wdata;
  end
endmodule : mfpc_mem_model

// file: mcu_fetch_pc_stack_core_tb_top.sv
// Self-checking bench of the instruction sequencing core
`timescale 1ns/1ns
module mcu_fetch_pc_stack_core_tb_top;
  import mfpc_pkg::*;
  logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, dm_we, int_req, int_ack, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [14:0] pm_addr;
  logic [15:0] pm_data;
  logic [7:0] dm_addr, dm_wdata, dm_rdata;
  logic [12:0] int_vector;
  logic [1:0] cycle_phase;
  int n_fail = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h0000_8C49;
  logic [14:0] m_pc;
  logic [15:0] m_ir;
  logic [7:0] m_acc, m_pcl_val;
  logic m_c, m_z, m_held, m_ipend, m_pcl_pend, ack_d;
  logic [1:0] m_bank;
  logic [7:0] dm_m [0:255];
  logic [14:0] m_stk [$];
  int ph;
  mfpc_phase_t ph_seq [4] = '{PH_T1, PH_T2, PH_T3, PH_T4};
  logic [3:0] fsel [15] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8,
    4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
  logic [15:0] fa [17] = '{16'h0008, 16'h0009, 16'h000A, 16'h000B, 16'h000C, 16'h000D, 16'h000E, 16'h000F,
    16'h0010, 16'h0011, 16'h0100, 16'h0101, 16'h0110, 16'h031C, 16'h0400, 16'h0500, 16'h0520};
  logic [15:0] fw [17] = '{16'h4230, 16'h1001, 16'h4031, 16'h4131, 16'h1002, 16'h4332, 16'h1003, 16'h6012,
    16'hC100, 16'hE300, 16'hC110, 16'h5000, 16'h5000, 16'h5000, 16'h5001, 16'hE500, 16'hE520};

  mfpc_core dut (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PM_ADDR(pm_addr),
    .PM_DATA(pm_data), .DM_ADDR(dm_addr), .DM_WDATA(dm_wdata), .DM_WE(dm_we), .DM_RDATA(dm_rdata),
    .INT_REQ(int_req), .INT_VECTOR(int_vector), .INT_ACK(int_ack), .CYCLE_PHASE(cycle_phase));
  mfpc_mem_model mem (.clk(core_clk), .pm_addr(pm_addr), .pm_data(pm_data), .dm_addr(dm_addr),
    .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_rdata(dm_rdata));

  // ----------------------------------------------------------------
  // Comparisons, bus cycles and the reference model
  // ----------------------------------------------------------------
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_val
  task automatic chk_flag(input logic got, input logic exp, input string what);
    chk_val({31'h0000_0000, got}, {31'h0000_0000, exp}, what);
  endtask : chk_flag
  task automatic finish_test();
    $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    // No wait-state count is assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Model sees bus writes only after this edge, like the core
    if (wr && a == ADDR_PCL) m_pcl_pend <= 1'b1;
    if (wr && a == ADDR_PCL) m_pcl_val <= wd[7:0];
    if (wr && a == ADDR_CTRL) m_bank <= wd[1:0];
    @(posedge core_clk);
  endtask : apb
  function automatic logic [7:0] alu(input logic [3:0] f, input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    case (f)
      4'h0: s = {1'b0, a} + {1'b0, b};
      4'h1: s = {1'b0, a} + {1'b0, b} + {8'h00, m_c};
      4'h2: s = {1'b0, a} + {1'b0, ~b} + 9'h001;
      4'h3: s = {1'b0, a} + {1'b0, ~b} + {8'h00, m_c};
      4'h5: s = {m_c, a & b};
      4'h6: s = {m_c, a | b};
      4'h8: s = {m_c, ~b};
      4'h9: s = {m_c, b[0], b[7:1]};
      4'hA: s = {b[0], m_c, b[7:1]};
      4'hB: s = {m_c, b[6:0], b[7]};
      4'hC: s = {b[7], b[6:0], m_c};
      4'hD: s = {m_c, b + 8'h01};
      4'hE: s = {m_c, b - 8'h01};
      4'hF: s = {m_c, a};
      default: s = {m_c, a ^ b};
    endcase
    m_c = s[8];
    // Rotates and the plain move keep the zero flag
    if (!(f inside {4'h9, 4'hA, 4'hB, 4'hC, 4'hF})) m_z = (s[7:0] == 8'h00);
    return s[7:0];
  endfunction : alu
  task automatic push();
    m_stk.push_back(m_pc);
    // Overflow drops the oldest entry
    if (m_stk.size() > STACK_LEVELS) void'(m_stk.pop_front());
  endtask : push
  task automatic redirect(input logic [14:0] t);
    m_pc = t;
    m_ir = OP_NOP;
  endtask : redirect
  task automatic step();
    logic [3:0] cls;
    logic [7:0] a;
    logic hit;
    cls = m_ir[15:12];
    a = m_ir[7:0];
    hit = 1'b0;
    chk_val({17'h0_0000, pm_addr}, {17'h0_0000, m_pc}, "fetch address");
    if (cls == CL_LALU && !m_held) begin
      m_held = 1'b1;
    end else begin
      m_held = 1'b0;
      case (cls)
        CL_ALU_IMM: m_acc = alu(m_ir[11:8], m_acc, a);
        CL_ALU_ACC: m_acc = alu(m_ir[11:8], m_acc, dm_m[a]);
        CL_ALU_MEM, CL_LALU: dm_m[a] = alu(m_ir[11:8], m_acc, dm_m[a]);
        CL_SKIP: begin
          if (m_ir[9]) dm_m[a] = m_ir[8] ? dm_m[a] - 8'h01 : dm_m[a] + 8'h01;
          hit = (dm_m[a] == 8'h00) ^ (m_ir[9:8] == SK_SNZ);
        end
        default: ;
      endcase
      if (m_ir[15:13] == TOP_CALL) push();
      if (m_ir[15:13] >= TOP_CALL) redirect({m_bank, m_ir[12:0]});
      else if (cls == CL_RET) redirect(m_stk.pop_back());
      else if (m_pcl_pend) begin
        redirect({m_pc[14:8], m_pcl_val});
        m_pcl_pend = 1'b0;
      end else if (hit) redirect(m_pc + 15'h0001);
      else if (m_ipend && m_stk.size() < STACK_LEVELS) begin
        push();
        redirect({2'b00, int_vector});
        m_ipend = 1'b0;
        ack_d = 1'b1;
      end else begin
        m_ir = mem.pm[m_pc];
        m_pc = m_pc + 15'h0001;
      end
    end
  endtask : step

  always @(posedge core_clk) begin
    if (sys_rst) begin
      ph = 0;
      m_pc = '0;
      m_ir = OP_NOP;
      m_acc = 8'h00;
      m_c = 1'b0;
      m_z = 1'b0;
      m_held = 1'b0;
      m_ipend = 1'b0;
      m_pcl_pend = 1'b0;
      m_bank = 2'b00;
      ack_d = 1'b0;
      m_stk.delete();
    end else begin
      chk_val({30'h0000_0000, cycle_phase}, {30'h0000_0000, ph_seq[ph]}, "phase");
      chk_flag(int_ack, ack_d, "interrupt acknowledge");
      ack_d = 1'b0;
      if (ph == 3) step();
      if (int_req) m_ipend = 1'b1;
      ph = (ph + 1) % 4;
    end
  end

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // The whole program needs well under a thousand cycles; the 30000-cycle limit marks a hang
  initial begin
    #(8 * 30000);
    n_fail++;
    finish_test();
  end
  initial begin : main
    logic [31:0] r;
    logic [3:0] cl;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    int_req = 1'b0;
    int_vector = 13'h0400;
    @(posedge core_clk);
    for (int i = 0; i < 256; i++) dm_m[i] = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r = xs();
      cl = 4'(1 + r[15:8] % 3);
      mem.pm[i] = {cl, fsel[r[23:16] % 15], (cl == CL_ALU_IMM) ? r[7:0] : {4'h1, r[3:0]}};
      mem.dm[8'h10 + i] = r[31:24];
      dm_m[8'h10 + i] = r[31:24];
    end
    for (int i = 0; i < 3; i++) begin
      mem.dm[8'h30 + i] = (i == 0) ? 8'hFF : 8'(5 - 4 * i);
      dm_m[8'h30 + i] = (i == 0) ? 8'hFF : 8'(5 - 4 * i);
    end
    for (int i = 0; i < 17; i++) mem.pm[fa[i]] = fw[i];
    // Nine nested calls overflow the eight-entry stack
    for (int i = 0; i < 9; i++) mem.pm[16'h0300 + 2 * i] = 16'hC302 + 16'(2 * i);
    for (int i = 0; i < 9; i++) mem.pm[16'h0301 + 2 * i] = 16'h5000;
    mem.pm[16'h0303] = 16'hE500;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    while (!(m_stk.size() == STACK_LEVELS && m_pc > 15'h0313)) begin
      @(posedge core_clk);
    end
    int_req <= 1'b1;
    @(posedge core_clk);
    int_req <= 1'b0;
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk_val(rd & 32'h0001_F000, 32'h0001_8000, "pending on full stack");
    while (m_pc[14:8] != 7'h05) begin
      @(posedge core_clk);
    end
    // Status is read-only: this write must leave depth and flags alone
    apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
    repeat (8) @(posedge core_clk);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk_val(rd & 32'h0001_F5FF, {15'h0000, m_ipend, 4'(m_stk.size()), 1'b0, m_z, 1'b0, m_c, m_acc},
      "status");
    chk_flag(err, 1'b0, "mapped error");
    for (int i = 0; i < 64; i++) chk_val({24'h00_0000, mem.dm[i]}, {24'h00_0000, dm_m[i]}, "memory");
    apb(1'b1, ADDR_PCL, 32'h0000_0020);
    repeat (24) @(posedge core_clk);
    apb(1'b0, ADDR_PCL, 32'h0000_0000);
    chk_val(rd & 32'h0000_00FE, 32'h0000_0020, "low byte read");
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk_flag(err, 1'b1, "unmapped error");
    chk_val(rd, 32'h0000_0000, "unmapped data");
    apb(1'b1, ADDR_CTRL, 32'h0000_0002);
    repeat (24) @(posedge core_clk);
    apb(1'b0, ADDR_CTRL, 32'h0000_0000);
    chk_val(rd & 32'h0000_0003, 32'h0000_0002, "bank select");
    finish_test();
  end
endmodule : mcu_fetch_pc_stack_core_tb_top
